// [test/diit_tb.sv]
/*
 * self-checking testbench for the dual internal interval timer: reset
 * values, control field masking, count gating, bound clearing, interrupt
 * pulses, causes, priority, pause end and sleep wake.
 * assumes diit_timers, diit_pkg and the constants header are compiled
 * first; after time zero all inputs are driven by non-blocking assignment at the edge.
 */
`timescale 1ns/100ps
`include "diit_consts.svh"

module testbench;

    // ------------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------------
    logic                          sys_clk;     // core clock
    logic                          rst_b;       // reset, active low
    diit_pkg::diit_csr_req_type    csr_req;     // csr request
    diit_pkg::diit_core_state_type core_state;  // core activity levels
    logic                          higher_irq;  // higher interrupt pending
    logic [31:0]                   csr_rdata;   // csr read data
    logic [31:0]                   mip_bits;    // pending bits
    logic                          irq_take;    // interrupt taken pulse
    logic [31:0]                   irq_cause;   // cause with take
    logic                          pause_end;   // pause end request
    logic                          sleep_wake;  // wake request
    int                            err_total;   // mismatches
    int                            n_checks;    // comparisons made
    int                            cycles;      // timeout counter

    diit_timers #(.W(32)) dut_u (
        .I_SYS_CLK    (sys_clk),
        .I_RST_B      (rst_b),
        .I_CSR_REQ    (csr_req),
        .I_CORE_STATE (core_state),
        .I_HIGHER_IRQ (higher_irq),
        .O_CSR_RDATA  (csr_rdata),
        .O_MIP_BITS   (mip_bits),
        .O_IRQ_TAKE   (irq_take),
        .O_IRQ_CAUSE  (irq_cause),
        .O_PAUSE_END  (pause_end),
        .O_SLEEP_WAKE (sleep_wake)
    );

    // ------------------------------------------------------------------
    // clock, inputs at time zero, hang guard
    // ------------------------------------------------------------------
    initial begin
        sys_clk    = 1'b0;
        rst_b      = 1'b0;
        csr_req    = '0;
        core_state = diit_pkg::diit_core_state_type'(5'h04);  // debug: counters hold
        higher_irq = 1'b0;
        err_total  = 0;
        n_checks   = 0;
        cycles     = 0;
    end
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one committed write, wr_en dropped at the following edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        csr_req.wr_en   <= 1'b1;
        csr_req.wr_addr <= a;
        csr_req.wr_data <= d;
        @(posedge sys_clk);
        csr_req.wr_en   <= 1'b0;
    endtask
    // read data lands one edge after rd_addr is driven
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        csr_req.rd_addr <= a;
        @(posedge sys_clk);
        #1 d = csr_rdata;
    endtask
    task automatic set_state(input logic [4:0] s);
        @(posedge sys_clk);
        core_state <= diit_pkg::diit_core_state_type'(s);
    endtask
    // settle, then look at one output for four cycles
    task automatic watch(input int sel, input logic t, input logic [31:0] c, input string name);
        logic seen;
        repeat (2) @(posedge sys_clk);
        repeat (4) begin
            @(posedge sys_clk);
            #1 seen = (sel == 0) ? irq_take : (sel == 1) ? pause_end : sleep_wake;
            check(name, {31'h0, t}, {31'h0, seen});
            if (sel == 0 && t) check("irq cause", c, irq_cause);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [11:0] a [7] = '{12'h7d2, 12'h7d3, 12'h7d4, 12'h7d5, 12'h7d6, 12'h7d7, 12'h7d8};
        logic [31:0] e [7] = '{32'h0, 32'hffff_ffff, 32'h1, 32'h0, 32'hffff_ffff, 32'h1, 32'h0};
        logic [31:0] v;
        for (int i = 0; i < 7; i++) begin
            rd(a[i], v);
            check("reset value", e[i], v);
        end
        $display("reset values done");
    endtask
    task automatic t_ctrl();
        logic [31:0] v;
        for (int i = 0; i < 2; i++) begin
            wr(i ? `DIIT_ADDR_CTRL1 : `DIIT_ADDR_CTRL0, 32'hffff_ffff);
            rd(i ? `DIIT_ADDR_CTRL1 : `DIIT_ADDR_CTRL0, v);
            check("control all ones", 32'h7, v);
            wr(i ? `DIIT_ADDR_CTRL1 : `DIIT_ADDR_CTRL0, 32'hffff_fff8);
            rd(i ? `DIIT_ADDR_CTRL1 : `DIIT_ADDR_CTRL0, v);
            check("control upper only", 32'h0, v);
        end
        $display("control masking done");
    endtask
    // two reads two cycles apart give the increment count
    task automatic t_gate();
        logic [2:0]  ctl [8] = '{3'h1, 3'h0, 3'h1, 3'h3, 3'h1, 3'h5, 3'h1, 3'h1};
        logic [4:0]  st  [8] = '{5'h00, 5'h00, 5'h10, 5'h10, 5'h08, 5'h08, 5'h04, 5'h06};
        logic [31:0] ex  [8] = '{32'h2, 32'h0, 32'h0, 32'h2, 32'h0, 32'h2, 32'h0, 32'h2};
        logic [31:0] a;
        logic [31:0] b;
        for (int i = 0; i < 8; i++) begin
            wr(`DIIT_ADDR_CTRL0, {29'h0, ctl[i]});
            set_state(st[i]);
            rd(`DIIT_ADDR_COUNT0, a);
            rd(`DIIT_ADDR_COUNT0, b);
            check("count step", ex[i], b - a);
        end
        set_state(5'h00);
        $display("count gating done");
    endtask
    task automatic t_irq();
        logic [31:0] v;
        int          n;
        wr(`DIIT_ADDR_MIE, 32'hffff_ffff);
        rd(`DIIT_ADDR_MIE, v);
        check("mie enables", 32'h3000_0000, v);
        wr(`DIIT_ADDR_CTRL0, 32'h0);
        wr(`DIIT_ADDR_CTRL1, 32'h0);
        wr(`DIIT_ADDR_LIMIT0, 32'h3);
        wr(`DIIT_ADDR_COUNT0, 32'h0);
        wr(`DIIT_ADDR_CTRL0, 32'h1);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (mip_bits[29] !== 1'b1 && n < 20);
        check("pending at bound", 32'h2000_0000, mip_bits);
        @(posedge sys_clk);
        #1 check("take pulse", 32'h1, {31'h0, irq_take});
        check("timer0 cause", `DIIT_CAUSE0, irq_cause);
        check("pending dropped", 32'h0, mip_bits);
        n = 1;
        do begin
            @(posedge sys_clk);
            #1 n++;
            if (n < 4) check("take low", 32'h0, {31'h0, irq_take});
        end while (mip_bits[29] !== 1'b1 && n < 20);
        check("hit period", 32'd4, n);
        $display("bound and pulse done");
    endtask
    task automatic t_prio();
        logic [31:0] v;
        wr(`DIIT_ADDR_LIMIT0, 32'h0);
        wr(`DIIT_ADDR_LIMIT1, 32'h0);
        wr(`DIIT_ADDR_CTRL1, 32'h1);
        watch(0, 1'b1, `DIIT_CAUSE0, "tie take");
        check("both pending", 32'h3000_0000, mip_bits);
        rd(`DIIT_ADDR_MIP, v);
        check("mip read", 32'h3000_0000, v);
        wr(`DIIT_ADDR_MIE, 32'h1000_0000);
        watch(0, 1'b1, `DIIT_CAUSE1, "timer1 take");
        wr(`DIIT_ADDR_MIE, 32'h3000_0000);
        @(posedge sys_clk);
        higher_irq <= 1'b1;
        watch(0, 1'b0, 32'h0, "higher wins");
        @(posedge sys_clk);
        higher_irq <= 1'b0;
        wr(`DIIT_ADDR_MIE, 32'h0);
        watch(0, 1'b0, 32'h0, "masked take");
        $display("priority done");
    endtask
    // count write in the same cycle as rd_addr, result seen after commit
    task automatic t_hitwr(input logic [31:0] lim, input logic [31:0] exp);
        wr(`DIIT_ADDR_CTRL0, 32'h0);
        wr(`DIIT_ADDR_LIMIT0, lim);
        @(posedge sys_clk);
        csr_req <= '{1'b1, `DIIT_ADDR_COUNT0, 32'h37, `DIIT_ADDR_COUNT0};
        @(posedge sys_clk);
        csr_req.wr_en <= 1'b0;
        @(posedge sys_clk);
        #1 check("count write", exp, csr_rdata);
    endtask
    task automatic t_wake();
        logic [2:0]  ctl [5] = '{3'h5, 3'h1, 3'h3, 3'h3, 3'h3};
        logic [4:0]  st  [5] = '{5'h08, 5'h08, 5'h10, 5'h11, 5'h10};
        logic [31:0] ie  [5] = '{32'h2000_0000, 32'h2000_0000, 32'h2000_0000,
                                 32'h2000_0000, 32'h0};
        int          sel [5] = '{1, 1, 2, 2, 2};
        logic        ex  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        wr(`DIIT_ADDR_LIMIT0, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(`DIIT_ADDR_MIE, ie[i]);
            wr(`DIIT_ADDR_CTRL0, {29'h0, ctl[i]});
            set_state(st[i]);
            watch(sel[i], ex[i], 32'h0, "end or wake");
        end
        set_state(5'h00);
        $display("pause end and wake done");
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        set_state(5'h00);
        t_ctrl();
        t_gate();
        t_irq();
        t_prio();
        t_hitwr(32'h0, 32'h0);
        t_hitwr(32'hffff_ffff, 32'h37);
        $display("count write at bound done");
        t_wake();
        stop_test();
    end

endmodule // testbench

// [verilog/diit_consts.svh]
/*
 * constants for the dual internal interval timer: csr addresses,
 * control field positions, reset values, interrupt bits and causes.
 * assumes a 12-bit csr address space and 32-bit csr data.
 */
`ifndef DIIT_CONSTS_SVH
`define DIIT_CONSTS_SVH

// ----------------------------------------------------------------------
// csr addresses
// ----------------------------------------------------------------------
`define DIIT_ADDR_COUNT0   12'h7d2
`define DIIT_ADDR_LIMIT0   12'h7d3
`define DIIT_ADDR_CTRL0    12'h7d4
`define DIIT_ADDR_COUNT1   12'h7d5
`define DIIT_ADDR_LIMIT1   12'h7d6
`define DIIT_ADDR_CTRL1    12'h7d7
`define DIIT_ADDR_MIE      12'h304
`define DIIT_ADDR_MIP      12'h344

// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define DIIT_CTRL_W        3
`define DIIT_CTRL_RST      3'h1
`define DIIT_COUNT_RST     32'h0000_0000
`define DIIT_LIMIT_RST     32'hffff_ffff

// ----------------------------------------------------------------------
// local interrupt bit positions in mip/mie and cause codes
// ----------------------------------------------------------------------
`define DIIT_IRQ_BIT0      29
`define DIIT_IRQ_BIT1      28
`define DIIT_CAUSE0        32'h8000_001d
`define DIIT_CAUSE1        32'h8000_001c

`endif

// [verilog/diit_pkg.sv]
/*
 * types for the dual internal interval timer: csr request, core state
 * and timer control carriers.
 * assumes the constants header is compiled alongside.
 */
package diit_pkg;

    // ------------------------------------------------------------------
    // csr access from the core, same clock domain
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr_en;    // write commits this cycle
        logic [11:0] wr_addr;  // csr write address
        logic [31:0] wr_data;  // csr write data
        logic [11:0] rd_addr;  // csr read address
    } diit_csr_req_type;

    // ------------------------------------------------------------------
    // core activity levels seen by the timers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sleep_halted;  // sleep halted state
        logic pausing;       // executing a pause
        logic debug_mode;    // in debug mode
        logic single_step;   // running a single-stepped instruction
        logic debug_halted;  // debug halted state
    } diit_core_state_type;

    // ------------------------------------------------------------------
    // per-timer control register fields, bit 2 down to bit 0
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pause_count_allow;
        logic sleep_count_allow;
        logic count_enable;
    } diit_ctrl_type;

endpackage

// [verilog/diit_timers.sv]
/*
 * dual internal interval timer: two 32-bit counters with bound and
 * control csrs, local interrupt pulses, cause selection, pause end and
 * sleep wake requests.
 * assumes csr requests and core state come from logic on I_SYS_CLK, and
 * that the core arbitrates the higher standard interrupts itself and
 * reports them on I_HIGHER_IRQ.
 */
`timescale 1ns/100ps
`include "diit_consts.svh"

module diit_timers #(
    parameter int W = 32  // counter and bound width
) (
    input  wire logic                           I_SYS_CLK,
    input  wire logic                           I_RST_B,
    input  wire diit_pkg::diit_csr_req_type     I_CSR_REQ,
    input  wire diit_pkg::diit_core_state_type  I_CORE_STATE,
    input  wire logic                           I_HIGHER_IRQ,
    output logic [31:0]                         O_CSR_RDATA,
    output logic [31:0]                         O_MIP_BITS,
    output logic                                O_IRQ_TAKE,
    output logic [31:0]                         O_IRQ_CAUSE,
    output logic                                O_PAUSE_END,
    output logic                                O_SLEEP_WAKE
);

    // ------------------------------------------------------------------
    // per-timer address and bit tables
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_COUNT [2] = '{`DIIT_ADDR_COUNT0, `DIIT_ADDR_COUNT1};
    localparam logic [11:0] ADDR_LIMIT [2] = '{`DIIT_ADDR_LIMIT0, `DIIT_ADDR_LIMIT1};
    localparam logic [11:0] ADDR_CTRL  [2] = '{`DIIT_ADDR_CTRL0, `DIIT_ADDR_CTRL1};
    localparam int          IRQ_BIT    [2] = '{`DIIT_IRQ_BIT0, `DIIT_IRQ_BIT1};

    // every check below runs on the core clock and rests during reset
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // ------------------------------------------------------------------
    // state and next values
    // ------------------------------------------------------------------
    logic [W-1:0]            count       [2];  // counters, step only while inc holds
    logic [W-1:0]            next_count  [2];
    logic [W-1:0]            limit       [2];  // bound registers
    logic [W-1:0]            next_limit  [2];
    diit_pkg::diit_ctrl_type ctrl        [2];  // control registers
    diit_pkg::diit_ctrl_type next_ctrl   [2];
    logic [1:0]              allow;            // mie enables, index = timer
    logic [1:0]              next_allow;
    logic [1:0]              hit;              // count at or above bound
    logic [1:0]              inc;              // increment conditions hold
    logic [1:0]              wr_cnt;           // write to a counter
    logic [1:0]              live;             // hit and enabled in mie
    logic [31:0]             next_rdata;       // read mux result
    logic                    next_take;        // interrupt taken
    logic [31:0]             next_cause;       // cause for the take
    logic                    next_pause_end;   // end the pause
    logic                    next_wake;        // wake from sleep

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    for (genvar t = 0; t < 2; t++) begin : g_tmr

        // bound compare, unsigned
        assign hit[t] = (count[t] >= limit[t]);

        // counter write strobe
        assign wr_cnt[t] = I_CSR_REQ.wr_en && (I_CSR_REQ.wr_addr == ADDR_COUNT[t]);

        // increment conditions
        always_comb begin
            inc[t] = ctrl[t].count_enable
                   && (!I_CORE_STATE.sleep_halted || ctrl[t].sleep_count_allow)
                   && (!I_CORE_STATE.pausing || ctrl[t].pause_count_allow)
                   && (!I_CORE_STATE.debug_mode || I_CORE_STATE.single_step);
        end

        // next counter, bound and control values
        always_comb begin
            next_count[t] = count[t];
            next_limit[t] = limit[t];
            next_ctrl[t]  = ctrl[t];
            if (hit[t]) begin
                // clearing beats a software write in the same cycle
                next_count[t] = `DIIT_COUNT_RST;
            end else if (wr_cnt[t]) begin
                // software value lands as written
                next_count[t] = I_CSR_REQ.wr_data[W-1:0];
            end else if (inc[t]) begin
                // one step per core clock
                next_count[t] = count[t] + W'(1);
            end
            if (I_CSR_REQ.wr_en && (I_CSR_REQ.wr_addr == ADDR_LIMIT[t])) begin
                // any bound value is legal
                next_limit[t] = I_CSR_REQ.wr_data[W-1:0];
            end
            if (I_CSR_REQ.wr_en && (I_CSR_REQ.wr_addr == ADDR_CTRL[t])) begin
                // only the three field bits are kept
                next_ctrl[t] = I_CSR_REQ.wr_data[`DIIT_CTRL_W-1:0];
            end
        end

        // timer registers
        always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
            if (!I_RST_B) begin
                count[t] <= `DIIT_COUNT_RST;
                limit[t] <= `DIIT_LIMIT_RST;
                ctrl[t]  <= `DIIT_CTRL_RST;
            end else begin
                count[t] <= next_count[t];
                limit[t] <= next_limit[t];
                ctrl[t]  <= next_ctrl[t];
            end
        end

        // --------------------------------------------------------------
        // timer checks
        // --------------------------------------------------------------
        // a hit is followed by a cleared counter
        sequence s_cleared;
            ##1 (count[t] == `DIIT_COUNT_RST);
        endsequence

        // a write landing without a hit is visible next cycle
        sequence s_written;
            ##1 (count[t] == $past(I_CSR_REQ.wr_data[W-1:0]));
        endsequence

        clear_on_hit_a : assert property (hit[t] |-> s_cleared)
            else $error("counter not cleared after reaching bound");

        write_lands_a : assert property (!hit[t] && wr_cnt[t] |-> s_written)
            else $error("counter write lost");

        count_step_a : assert property (
            !hit[t] && !wr_cnt[t] && inc[t] |=> count[t] == $past(count[t]) + W'(1))
            else $error("counter did not step by one");

        debug_hold_a : assert property (
            I_CORE_STATE.debug_mode && !I_CORE_STATE.single_step && !hit[t]
            && !wr_cnt[t] |=> $stable(count[t]))
            else $error("counter moved in debug mode");

        sleep_hold_a : assert property (
            I_CORE_STATE.sleep_halted && !ctrl[t].sleep_count_allow && !hit[t]
            && !wr_cnt[t] |=> $stable(count[t]))
            else $error("counter moved in sleep without allowance");

        pause_hold_a : assert property (
            I_CORE_STATE.pausing && !ctrl[t].pause_count_allow && !hit[t]
            && !wr_cnt[t] |=> $stable(count[t]))
            else $error("counter moved in pause without allowance");

        ctrl_read_a : assert property (
            I_CSR_REQ.rd_addr == ADDR_CTRL[t]
            |=> O_CSR_RDATA[31:`DIIT_CTRL_W] == '0
                && O_CSR_RDATA[`DIIT_CTRL_W-1:0] == $past(ctrl[t]))
            else $error("control read shows illegal bits");

        pending_pulse_a : assert property (
            O_MIP_BITS[IRQ_BIT[t]] == hit[t] && O_MIP_BITS[IRQ_BIT[t]] |=> count[t] == '0)
            else $error("pending bit not a single-cycle pulse");

        // a bound write lands exactly as written
        limit_write_a : assert property (
            I_CSR_REQ.wr_en && I_CSR_REQ.wr_addr == ADDR_LIMIT[t]
            |=> limit[t] == $past(I_CSR_REQ.wr_data[W-1:0]))
            else $error("bound write lost");

        // a control write keeps only the three field bits
        ctrl_write_a : assert property (
            I_CSR_REQ.wr_en && I_CSR_REQ.wr_addr == ADDR_CTRL[t]
            |=> ctrl[t] == $past(I_CSR_REQ.wr_data[`DIIT_CTRL_W-1:0]))
            else $error("control write not kept legal");
    end

    // ------------------------------------------------------------------
    // mie enable bits for the two local interrupts
    // ------------------------------------------------------------------
    always_comb begin
        next_allow = allow;
        if (I_CSR_REQ.wr_en && (I_CSR_REQ.wr_addr == `DIIT_ADDR_MIE)) begin
            // timer 0 enable in bit 29, timer 1 in bit 28
            next_allow = {I_CSR_REQ.wr_data[`DIIT_IRQ_BIT1],
                          I_CSR_REQ.wr_data[`DIIT_IRQ_BIT0]};
        end
    end

    // mie enable register, both clear at reset
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            allow <= 2'h0;
        end else begin
            allow <= next_allow;
        end
    end

    // pending bits, unlatched so they show only while at or above the bound
    always_comb begin
        O_MIP_BITS                 = 32'h0000_0000;
        O_MIP_BITS[`DIIT_IRQ_BIT0] = hit[0];
        O_MIP_BITS[`DIIT_IRQ_BIT1] = hit[1];
    end

    // ------------------------------------------------------------------
    // interrupt selection, pause end and sleep wake
    // ------------------------------------------------------------------
    always_comb begin
        live           = hit & allow;
        // higher standard interrupts suppress this cycle's pulse
        next_take      = (|live) && !I_HIGHER_IRQ;
        // timer 0 first when both fire together
        next_cause     = live[0] ? `DIIT_CAUSE0 : `DIIT_CAUSE1;
        // pause ends only on a timer that may count while pausing
        next_pause_end = I_CORE_STATE.pausing && !I_CORE_STATE.debug_halted
                       && ((live[0] && ctrl[0].pause_count_allow)
                           || (live[1] && ctrl[1].pause_count_allow));
        // sleep wake ignored in the debug halted state
        next_wake      = I_CORE_STATE.sleep_halted && !I_CORE_STATE.debug_halted
                       && ((live[0] && ctrl[0].sleep_count_allow)
                           || (live[1] && ctrl[1].sleep_count_allow));
    end

    // ------------------------------------------------------------------
    // csr read mux, unmapped addresses read zero
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (I_CSR_REQ.rd_addr)
            `DIIT_ADDR_COUNT0 : next_rdata = 32'(count[0]);
            `DIIT_ADDR_LIMIT0 : next_rdata = 32'(limit[0]);
            `DIIT_ADDR_CTRL0  : next_rdata = {29'h0000_0000, ctrl[0]};
            `DIIT_ADDR_COUNT1 : next_rdata = 32'(count[1]);
            `DIIT_ADDR_LIMIT1 : next_rdata = 32'(limit[1]);
            `DIIT_ADDR_CTRL1  : next_rdata = {29'h0000_0000, ctrl[1]};
            `DIIT_ADDR_MIE    : begin
                next_rdata[`DIIT_IRQ_BIT0] = allow[0];
                next_rdata[`DIIT_IRQ_BIT1] = allow[1];
            end
            `DIIT_ADDR_MIP    : next_rdata = O_MIP_BITS;
            default           : next_rdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_CSR_RDATA  <= 32'h0000_0000;
            O_IRQ_TAKE   <= 1'b0;
            O_IRQ_CAUSE  <= 32'h0000_0000;
            O_PAUSE_END  <= 1'b0;
            O_SLEEP_WAKE <= 1'b0;
        end else begin
            O_CSR_RDATA  <= next_rdata;
            O_IRQ_TAKE   <= next_take;
            O_IRQ_CAUSE  <= next_cause;
            O_PAUSE_END  <= next_pause_end;
            O_SLEEP_WAKE <= next_wake;
        end
    end

    // ------------------------------------------------------------------
    // block-level checks
    // ------------------------------------------------------------------
    // both timers firing together, both enabled
    sequence s_both_fire;
        hit[0] && hit[1] && allow[0] && allow[1] && !I_HIGHER_IRQ;
    endsequence

    take_prio_a : assert property (
        s_both_fire |=> O_IRQ_TAKE && O_IRQ_CAUSE == `DIIT_CAUSE0)
        else $error("timer 0 did not win a tie");

    take_t1_a : assert property (
        hit[1] && allow[1] && !(hit[0] && allow[0]) && !I_HIGHER_IRQ
        |=> O_IRQ_TAKE && O_IRQ_CAUSE == `DIIT_CAUSE1)
        else $error("timer 1 cause wrong");

    higher_wins_a : assert property (I_HIGHER_IRQ |=> !O_IRQ_TAKE)
        else $error("timer interrupt beat a higher one");

    mask_gate_a : assert property (
        (hit & allow) == 2'h0 |=> !O_IRQ_TAKE && !O_PAUSE_END && !O_SLEEP_WAKE)
        else $error("masked timer interrupt had an effect");

    debug_nowake_a : assert property (I_CORE_STATE.debug_halted |=> !O_SLEEP_WAKE)
        else $error("woke from debug halted state");

    sleep_wake_a : assert property (
        I_CORE_STATE.sleep_halted && !I_CORE_STATE.debug_halted && hit[0] && allow[0]
        && ctrl[0].sleep_count_allow |=> O_SLEEP_WAKE)
        else $error("sleep not ended by timer");

    pause_end_a : assert property (
        I_CORE_STATE.pausing && !I_CORE_STATE.debug_halted && hit[1] && allow[1]
        && ctrl[1].pause_count_allow |=> O_PAUSE_END)
        else $error("pause not ended by timer");

    mie_write_a : assert property (
        I_CSR_REQ.wr_en && I_CSR_REQ.wr_addr == `DIIT_ADDR_MIE
        |=> allow == {$past(I_CSR_REQ.wr_data[`DIIT_IRQ_BIT1]),
                      $past(I_CSR_REQ.wr_data[`DIIT_IRQ_BIT0])})
        else $error("mie enable bits not stored");

    // a take needs an enabled timer at its bound one cycle earlier
    take_source_a : assert property (
        O_IRQ_TAKE |-> $past(live) != 2'h0)
        else $error("take without an enabled hit");

    // timer 1 wakes the core as well
    wake_timer1_a : assert property (
        I_CORE_STATE.sleep_halted && !I_CORE_STATE.debug_halted && hit[1] && allow[1]
        && ctrl[1].sleep_count_allow |=> O_SLEEP_WAKE)
        else $error("sleep not ended by timer 1");

    // timer 0 ends a pause as well
    pause_timer0_a : assert property (
        I_CORE_STATE.pausing && !I_CORE_STATE.debug_halted && hit[0] && allow[0]
        && ctrl[0].pause_count_allow |=> O_PAUSE_END)
        else $error("pause not ended by timer 0");

endmodule // diit_timers
